// ---- bench/tlm_host.sv ----
`timescale 1ns/1ps
module tlm_host
    import tlm_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire tlm_pkg::tlm_word_t rd_data_i,
    input  wire logic               rd_valid_i,
    output logic                    rd_en_o,
    output tlm_pkg::tlm_addr_t      rd_addr_o
);
    import tlm_pkg::*;

    initial begin
        rd_en_o   = 1'b0;
        rd_addr_o = 8'h00;
    end

    // One word read: the strobe stands for one edge and the answer comes on the next.
    task automatic rd(input tlm_addr_t a, output tlm_word_t d, output logic ok);
        @(posedge sys_clk_i);
        rd_en_o   <= 1'b1;
        rd_addr_o <= a;
        @(posedge sys_clk_i);
        rd_en_o   <= 1'b0;
        rd_addr_o <= ~a; // A released address must not keep its last value.
        @(negedge sys_clk_i);
        d  = rd_data_i;
        ok = rd_valid_i;
    endtask
endmodule

// ---- bench/tlm_regs_tb.sv ----
`timescale 1ns/1ps
`include "tlm_cfg.svh"
module tlm_regs_tb;
    import tlm_pkg::*;
    logic      sys_clk_i = 1'b0;
    logic      rst_n_i   = 1'b0;
    logic      ov_pin    = 1'b0;
    logic      uv_pin    = 1'b0;
    logic      sh_pin    = 1'b0;
    logic [4:0] evt_v    = 5'h0;
    logic      clr       = 1'b0;
    logic      cv        = 1'b0;
    logic      vv        = 1'b0;
    tlm_meas_t cs        = 12'h000;
    tlm_meas_t vs        = 12'h000;
    tlm_word_t fr        = 16'h0000;
    tlm_word_t im        = 16'h0000;
    tlm_word_t dac       = 16'h0000;
    tlm_word_t rdata;
    tlm_word_t exp;
    logic      rvalid;
    logic      en;
    tlm_addr_t addr;
    int        seed = 67065;
    int        err_count = 0;
    int        checks_done = 0;
    int        cyc = 0;
    int        sc;
    int        sv;
    int        r;
    int        pos[5] = '{10, 9, 2, 1, 5};

    tlm_regs dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .overvolt_compare_flag_i(ov_pin),
        .undervolt_compare_flag_i(uv_pin), .sense_pin_short_flag_i(sh_pin),
        .ar_ov_evt_i(evt_v[0]), .ar_uv_evt_i(evt_v[1]), .lo_ov_evt_i(evt_v[2]),
        .lo_uv_evt_i(evt_v[3]), .turnoff_cmd_evt_i(evt_v[4]), .sticky_clr_i(clr),
        .cur_smp_valid_i(cv), .cur_smp_i(cs), .volt_smp_valid_i(vv), .volt_smp_i(vs),
        .fault_resp_i(fr), .int_mask_status_i(im), .dac_setting_i(dac),
        .rd_en_i(en), .rd_addr_i(addr), .rd_data_o(rdata), .rd_valid_o(rvalid));
    tlm_host host (.sys_clk_i(sys_clk_i), .rd_data_i(rdata), .rd_valid_i(rvalid),
        .rd_en_o(en), .rd_addr_o(addr));

    // Clock and a cycle ceiling so that a hang cannot stall the run.
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end

    // Read one word and compare it with the model's value.
    task automatic rdchk(input tlm_addr_t a, input tlm_word_t e);
        tlm_word_t d;
        logic      ok;
        host.rd(a, d, ok);
        checks_done++;
        if (ok !== 1'b1 || d !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, d, e);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        fr      <= 16'($random(seed));
        im      <= 16'($random(seed));
        dac     <= 16'($random(seed));
        repeat (4) @(posedge sys_clk_i);
        rdchk(`TLM_OFS_FAULT_RESP, fr);
        rdchk(`TLM_OFS_INT_MASK, im);
        rdchk(`TLM_OFS_DAC, dac);
        rdchk(`TLM_OFS_LIVE, 16'h0000);
        rdchk(`TLM_OFS_STICKY, 16'h0000);
        rdchk(`TLM_OFS_AVG_CUR, 16'h0000);
        rdchk(8'h02, 16'h0000);
        $display("test reset and pass-through done");
        // Live bits follow eight random pin combinations, each read back after it settles.
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            @(posedge sys_clk_i);
            ov_pin <= r[0];
            uv_pin <= r[1];
            sh_pin <= r[2];
            repeat (6) @(posedge sys_clk_i);
            rdchk(`TLM_OFS_LIVE, {12'h000, r[2], 1'b0, r[1], r[0]});
        end
        // A pin level that lasts one cycle only is a glitch and must not show.
        @(posedge sys_clk_i);
        ov_pin <= ~r[0];
        @(posedge sys_clk_i);
        ov_pin <= r[0];
        repeat (6) @(posedge sys_clk_i);
        rdchk(`TLM_OFS_LIVE, {12'h000, r[2], 1'b0, r[1], r[0]});
        $display("test live status done");
        // Sticky bits gather one by one and hold between pulses.
        exp = 16'h0000;
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk_i);
            evt_v <= 5'(1 << k);
            @(posedge sys_clk_i);
            evt_v <= 5'h0;
            exp = exp | 16'(1 << pos[k]);
            rdchk(`TLM_OFS_STICKY, exp);
        end
        // A clear with coinciding events keeps the events' bits and drops the rest.
        @(posedge sys_clk_i);
        clr   <= 1'b1;
        evt_v <= 5'h09;
        @(posedge sys_clk_i);
        clr   <= 1'b0;
        evt_v <= 5'h0;
        rdchk(`TLM_OFS_STICKY, 16'h0402);
        $display("test sticky status done");
        // Two windows of sixteen back-to-back samples, no carry between them.
        for (int w = 0; w < 2; w++) begin
            sc = 0;
            sv = 0;
            for (int i = 0; i < 16; i++) begin
                r = $random(seed);
                @(posedge sys_clk_i);
                cv <= 1'b1;
                vv <= 1'b1;
                cs <= r[11:0];
                vs <= r[27:16];
                sc += r[11:0];
                sv += r[27:20];
            end
            @(posedge sys_clk_i);
            cv <= 1'b0;
            vv <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
            rdchk(`TLM_OFS_AVG_CUR, {4'h0, 12'(sc >> 4)});
            rdchk(`TLM_OFS_AVG_VOLT, {8'h00, 8'(sv >> 4)});
            rdchk(`TLM_OFS_MEAS_CUR, {4'h0, r[11:0]});
            rdchk(`TLM_OFS_MEAS_VOLT, {4'h0, r[27:16]});
        end
        $display("test averages done");
        finish_test();
    end
endmodule

// ---- hw/tlm_avg16.sv ----
`timescale 1ns/1ps
`include "tlm_cfg.svh"
module tlm_avg16 #(
    parameter int W = 12
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         smp_valid_i,
    input  wire logic [W-1:0] smp_i,
    output logic      [W-1:0] avg_o,
    output logic              avg_valid_o
);
    typedef struct packed {
        logic [W+3:0] acc;
        logic [3:0]   cnt;
        logic [W-1:0] avg;
        logic         done;
    } tlm_avg_s;

    tlm_avg_s st_r;
    tlm_avg_s st_nxt;
    logic [W+3:0] sum_w;

    // ------------------------------------------------------------------------
    // Accumulate sixteen samples, then publish the mean.
    // ------------------------------------------------------------------------
    // Dividing by sixteen is a shift, so no divider is needed; the result truncates.
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        sum_w       = st_r.acc + {4'h0, smp_i};
        if (smp_valid_i) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
            if (st_r.cnt == `TLM_AVG_LAST) begin
                st_nxt.avg  = sum_w[W+3:`TLM_AVG_SHIFT];
                st_nxt.acc  = '0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.acc = sum_w;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avg_o       = st_r.avg;
    assign avg_valid_o = st_r.done;

    // Mean of the window lands one cycle after its sixteenth sample.
    avg_result_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        smp_valid_i && st_r.cnt == `TLM_AVG_LAST |=>
            avg_valid_o && avg_o == $past(sum_w[W+3:`TLM_AVG_SHIFT]) && st_r.acc == '0)
        else $error("average not published after sixteenth sample");
endmodule

// ---- hw/tlm_cfg.svh ----
`ifndef TLM_CFG_SVH
`define TLM_CFG_SVH
// How it works
// - The average current word carries the mean of sixteen successive current samples in its low twelve bits and reads zero above them.
// - The average voltage word carries the mean of sixteen successive voltage samples in its low eight bits and reads zero above them.
// - The live status word shows the undervoltage comparator at bit 1 and the overvoltage comparator at bit 0.
// - The live status word shows bit 3 while a short of the current-sense pin is seen.
// - The sticky status word sets bit 10 on an overvoltage auto-restart and bit 9 on an undervoltage auto-restart.
// - The sticky status word sets bit 2 on an overvoltage latch-off and bit 1 on an undervoltage latch-off.
// - The sticky status word sets bit 5 once a supply turn-off command has been received.

// ----------------------------------------------------------------------------
// Register sub-addresses
// ----------------------------------------------------------------------------
`define TLM_OFS_FAULT_RESP  8'h0C
`define TLM_OFS_MEAS_CUR    8'h0E
`define TLM_OFS_MEAS_VOLT   8'h12
`define TLM_OFS_LIVE        8'h14
`define TLM_OFS_STICKY      8'h16
`define TLM_OFS_INT_MASK    8'h18
`define TLM_OFS_AVG_CUR     8'h1A
`define TLM_OFS_AVG_VOLT    8'h1C
`define TLM_OFS_DAC         8'h1E

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define TLM_LIVE_OV_BIT     0
`define TLM_LIVE_UV_BIT     1
`define TLM_LIVE_ISSC_BIT   3
`define TLM_STK_LO_UV_BIT   1
`define TLM_STK_LO_OV_BIT   2
`define TLM_STK_OFF_BIT     5
`define TLM_STK_AR_UV_BIT   9
`define TLM_STK_AR_OV_BIT   10
`define TLM_MEAS_W          12
`define TLM_AVG_CUR_W       12
`define TLM_AVG_VOLT_W      8
`define TLM_VOLT_AVG_LSB    4

// ----------------------------------------------------------------------------
// Averaging
// ----------------------------------------------------------------------------
`define TLM_AVG_LAST        4'hF
`define TLM_AVG_SHIFT       4
`define TLM_WORD_ZERO       16'h0000
`endif

// ---- hw/tlm_pkg.sv ----
package tlm_pkg;
    typedef logic [15:0] tlm_word_t;
    typedef logic [7:0]  tlm_addr_t;
    typedef logic [11:0] tlm_meas_t;

    // State of the register bank, apart from the two averagers.
    typedef struct packed {
        logic [2:0] ov_sync;
        logic [2:0] uv_sync;
        logic [2:0] issc_sync;
        logic       ov_live;
        logic       uv_live;
        logic       issc_live;
        logic       ar_ov;
        logic       ar_uv;
        logic       lo_ov;
        logic       lo_uv;
        logic       turnoff;
        tlm_meas_t  cur_last;
        tlm_meas_t  volt_last;
        tlm_word_t  rd_data;
        logic       rd_valid;
    } tlm_state_s;
endpackage

// ---- hw/tlm_regs.sv ----
`timescale 1ns/1ps
`include "tlm_cfg.svh"
module tlm_regs
    import tlm_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire logic                rst_n_i,
    // Comparator pins, asynchronous to sys_clk_i.
    input  wire logic                overvolt_compare_flag_i,
    input  wire logic                undervolt_compare_flag_i,
    input  wire logic                sense_pin_short_flag_i,
    // Fault and command events from the controller, one-cycle pulses.
    input  wire logic                ar_ov_evt_i,
    input  wire logic                ar_uv_evt_i,
    input  wire logic                lo_ov_evt_i,
    input  wire logic                lo_uv_evt_i,
    input  wire logic                turnoff_cmd_evt_i,
    input  wire logic                sticky_clr_i,
    // Measurement samples.
    input  wire logic                cur_smp_valid_i,
    input  wire tlm_pkg::tlm_meas_t  cur_smp_i,
    input  wire logic                volt_smp_valid_i,
    input  wire tlm_pkg::tlm_meas_t  volt_smp_i,
    // Words owned by other blocks, shown as they are.
    input  wire tlm_pkg::tlm_word_t  fault_resp_i,
    input  wire tlm_pkg::tlm_word_t  int_mask_status_i,
    input  wire tlm_pkg::tlm_word_t  dac_setting_i,
    // Read port.
    input  wire logic                rd_en_i,
    input  wire tlm_pkg::tlm_addr_t  rd_addr_i,
    output tlm_pkg::tlm_word_t       rd_data_o,
    output logic                     rd_valid_o
);
    import tlm_pkg::*;

    tlm_state_s                   st_r;
    tlm_state_s                   st_nxt;
    logic [`TLM_AVG_CUR_W-1:0]    avg_cur_w;
    logic [`TLM_AVG_VOLT_W-1:0]   avg_volt_w;
    tlm_word_t                    live_w;
    tlm_word_t                    sticky_w;
    tlm_word_t                    mux_w;

    // ------------------------------------------------------------------------
    // Averagers
    // ------------------------------------------------------------------------
    tlm_avg16 #(.W(`TLM_AVG_CUR_W)) u_avg_cur (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .smp_valid_i (cur_smp_valid_i),
        .smp_i       (cur_smp_i),
        .avg_o       (avg_cur_w),
        .avg_valid_o ()
    );

    // The voltage mean keeps only the top eight bits of each sample.
    tlm_avg16 #(.W(`TLM_AVG_VOLT_W)) u_avg_volt (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .smp_valid_i (volt_smp_valid_i),
        .smp_i       (volt_smp_i[`TLM_MEAS_W-1:`TLM_VOLT_AVG_LSB]),
        .avg_o       (avg_volt_w),
        .avg_valid_o ()
    );

    // ------------------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------------------
    // Live and sticky words built from the state bits; unlisted bits read zero.
    always_comb begin
        live_w                        = `TLM_WORD_ZERO;
        live_w[`TLM_LIVE_OV_BIT]      = st_r.ov_live;
        live_w[`TLM_LIVE_UV_BIT]      = st_r.uv_live;
        live_w[`TLM_LIVE_ISSC_BIT]    = st_r.issc_live;
        sticky_w                      = `TLM_WORD_ZERO;
        sticky_w[`TLM_STK_AR_OV_BIT]  = st_r.ar_ov;
        sticky_w[`TLM_STK_AR_UV_BIT]  = st_r.ar_uv;
        sticky_w[`TLM_STK_LO_OV_BIT]  = st_r.lo_ov;
        sticky_w[`TLM_STK_LO_UV_BIT]  = st_r.lo_uv;
        sticky_w[`TLM_STK_OFF_BIT]    = st_r.turnoff;
    end

    // Address decode; an unmapped sub-address reads as zero.
    always_comb begin
        case (rd_addr_i)
            `TLM_OFS_FAULT_RESP: mux_w = fault_resp_i;
            `TLM_OFS_MEAS_CUR:   mux_w = {4'h0, st_r.cur_last};
            `TLM_OFS_MEAS_VOLT:  mux_w = {4'h0, st_r.volt_last};
            `TLM_OFS_LIVE:       mux_w = live_w;
            `TLM_OFS_STICKY:     mux_w = sticky_w;
            `TLM_OFS_INT_MASK:   mux_w = int_mask_status_i;
            `TLM_OFS_AVG_CUR:    mux_w = {4'h0, avg_cur_w};
            `TLM_OFS_AVG_VOLT:   mux_w = {8'h00, avg_volt_w};
            `TLM_OFS_DAC:        mux_w = dac_setting_i;
            default:             mux_w = `TLM_WORD_ZERO;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Comparators pass three flops; a new level is taken only when stages two
    // and three agree, which rejects a single-cycle glitch on the pin.
    always_comb begin
        st_nxt           = st_r;
        st_nxt.ov_sync   = {st_r.ov_sync[1:0], overvolt_compare_flag_i};
        st_nxt.uv_sync   = {st_r.uv_sync[1:0], undervolt_compare_flag_i};
        st_nxt.issc_sync = {st_r.issc_sync[1:0], sense_pin_short_flag_i};
        if (st_r.ov_sync[1] == st_r.ov_sync[2]) begin
            st_nxt.ov_live = st_r.ov_sync[1];
        end
        if (st_r.uv_sync[1] == st_r.uv_sync[2]) begin
            st_nxt.uv_live = st_r.uv_sync[1];
        end
        if (st_r.issc_sync[1] == st_r.issc_sync[2]) begin
            st_nxt.issc_live = st_r.issc_sync[1];
        end
        // Sticky bits: a set in the cycle of a clear still wins.
        st_nxt.ar_ov   = (st_r.ar_ov & ~sticky_clr_i) | ar_ov_evt_i;
        st_nxt.ar_uv   = (st_r.ar_uv & ~sticky_clr_i) | ar_uv_evt_i;
        st_nxt.lo_ov   = (st_r.lo_ov & ~sticky_clr_i) | lo_ov_evt_i;
        st_nxt.lo_uv   = (st_r.lo_uv & ~sticky_clr_i) | lo_uv_evt_i;
        st_nxt.turnoff = (st_r.turnoff & ~sticky_clr_i) | turnoff_cmd_evt_i;
        if (cur_smp_valid_i) begin
            st_nxt.cur_last = cur_smp_i;
        end
        if (volt_smp_valid_i) begin
            st_nxt.volt_last = volt_smp_i;
        end
        // Read data holds its value between reads so a slow host sees it stable.
        st_nxt.rd_valid = rd_en_i;
        if (rd_en_i) begin
            st_nxt.rd_data = mux_w;
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_o  = st_r.rd_data;
    assign rd_valid_o = st_r.rd_valid;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    ov_live_follow_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.ov_sync[2] == st_r.ov_sync[1] |=> st_r.ov_live == $past(st_r.ov_sync[1]))
        else $error("overvoltage live bit missed a settled level");

    uv_live_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.uv_sync[2] != st_r.uv_sync[1] |=> $stable(st_r.uv_live))
        else $error("undervoltage live bit moved on an unsettled level");

    short_live_read_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_en_i && rd_addr_i == `TLM_OFS_LIVE |=>
            rd_valid_o && rd_data_o[`TLM_LIVE_ISSC_BIT] == $past(st_r.issc_live)
            && rd_data_o[`TLM_LIVE_UV_BIT] == $past(st_r.uv_live)
            && rd_data_o[`TLM_LIVE_OV_BIT] == $past(st_r.ov_live))
        else $error("live status word misplaced a comparator bit");

    // An auto-restart event shows in the sticky word from the very next cycle.
    autorestart_set_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ar_ov_evt_i || ar_uv_evt_i |=>
            (!$past(ar_ov_evt_i) || sticky_w[`TLM_STK_AR_OV_BIT])
            && (!$past(ar_uv_evt_i) || sticky_w[`TLM_STK_AR_UV_BIT]))
        else $error("auto-restart event not reported in the sticky word");

    latchoff_set_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        lo_uv_evt_i && sticky_clr_i |=> st_r.lo_uv [*1] ##0 sticky_w[`TLM_STK_LO_UV_BIT])
        else $error("undervoltage latch-off lost against a clear");

    turnoff_seen_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        turnoff_cmd_evt_i ##1 !sticky_clr_i [*2] |=> sticky_w[`TLM_STK_OFF_BIT])
        else $error("turn-off command not held at bit 5");

    sticky_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        sticky_clr_i && !ar_uv_evt_i |=> !st_r.ar_uv)
        else $error("sticky bit survived a clear with no new event");

    avg_cur_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_en_i && rd_addr_i == `TLM_OFS_AVG_CUR |=>
            rd_data_o[15:12] == 4'h0 && rd_data_o[11:0] == $past(avg_cur_w))
        else $error("average current word malformed");

    avg_volt_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_en_i && rd_addr_i == `TLM_OFS_AVG_VOLT |=>
            rd_data_o[15:8] == 8'h00 && rd_data_o[7:0] == $past(avg_volt_w))
        else $error("average voltage word malformed");

    // The short flag takes a settled pin level one cycle after it settles.
    short_live_follow_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.issc_sync[2] == st_r.issc_sync[1] |=> st_r.issc_live == $past(st_r.issc_sync[1]))
        else $error("short live bit missed a settled level");

    // An unsettled short pin must not move the live bit, or a glitch would show.
    short_live_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.issc_sync[2] != st_r.issc_sync[1] |=> $stable(st_r.issc_live))
        else $error("short live bit moved on an unsettled level");

    // A latched fault stays set for as long as no clear arrives.
    latchoff_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.lo_ov && !sticky_clr_i |=> st_r.lo_ov)
        else $error("overvoltage latch-off bit dropped without a clear");

    // A clear with no fresh command empties the turn-off bit.
    turnoff_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        sticky_clr_i && !turnoff_cmd_evt_i |=> !st_r.turnoff)
        else $error("turn-off bit survived a clear with no new command");
endmodule
